// ==== hw/abir_pkg.sv ====
/*
 * abir_pkg: register map, field positions, reset values and frame lengths
 * for the asynchronous serial port with break and queued idle.
 * assumes: a single 100 MHz bus clock; APB3 register access, 32-bit data.
 */
package abir_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_BAUD    = 8'h04;
    localparam logic [7:0] OFF_TXDATA  = 8'h08;
    localparam logic [7:0] OFF_RXDATA  = 8'h0c;
    localparam logic [7:0] OFF_STATUS  = 8'h10;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
    localparam logic [7:0] OFF_IRQ_EN  = 8'h18;
    localparam logic [7:0] OFF_STATE   = 8'h1c;

    // ------------------------------------------------------------------
    // control register bit positions
    // ------------------------------------------------------------------
    localparam int CTRL_TX_ON     = 0;
    localparam int CTRL_RX_ON     = 1;
    localparam int CTRL_BRK_REQ   = 2;
    localparam int CTRL_LONG_BRK  = 3;
    localparam int CTRL_NINE_BIT  = 4;
    localparam int CTRL_RX_INV    = 5;

    // ------------------------------------------------------------------
    // status (sticky) bit positions
    // ------------------------------------------------------------------
    localparam int ST_TX_EMPTY    = 0;
    localparam int ST_RX_FULL     = 1;
    localparam int ST_FRAME_ERR   = 2;
    localparam int ST_OVERRUN     = 3;
    localparam int ST_TX_DONE     = 4;
    localparam int ST_W           = 5;

    // ------------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------------
    localparam logic [5:0]  CTRL_RST  = 6'h00;
    // 100 MHz / (115200 * 16) - 1, oversample period in bus cycles minus one
    localparam logic [15:0] BAUD_RST  = 16'h0035;
    localparam logic [3:0]  OS_LAST   = 4'hf;
    localparam logic [3:0]  OS_MID    = 4'h7;

    // character lengths in bit times, start and stop included
    localparam logic [3:0]  LEN_CHAR8 = 4'ha;
    localparam logic [3:0]  LEN_CHAR9 = 4'hb;
    localparam logic [3:0]  LEN_LONG_BREAK_SELECT = 4'hd;
    localparam logic [3:0]  LEN_BRK14 = 4'he;

    typedef enum logic [1:0] {
        KIND_NONE,
        KIND_DATA,
        KIND_BREAK,
        KIND_IDLE
    } abir_kind_t;

endpackage

// ==== hw/abir_rx.sv ====
/*
 * abir_rx: 16x oversampling receive shifter; hands whole characters to the core.
 * assumes: rxd already synchronous to pclk; os_tick is a one-cycle enable.
 */
`timescale 1ns/1ns
module abir_rx (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // core link
    abir_rx_if.rx     lnk
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } abir_rx_st_t;

    typedef struct packed {
        abir_rx_st_t st;
        logic [3:0]  os;
        logic [3:0]  nbits;
        logic [8:0]  sh;
        logic        valid;
        logic [8:0]  data;
        logic        ferr;
    } abir_rx_t;

    abir_rx_t r;
    abir_rx_t n;
    logic     s;

    always_comb
    begin
        n       = r;
        n.valid = 1'b0;
        s = lnk.rxd ^ lnk.rx_inv;
        if (lnk.os_tick)
        begin
            n.os = r.os + 4'h1;
            case (r.st)
                RX_IDLE:
                begin
                    if (!s)
                    begin
                        n.st = RX_START;
                        n.os = 4'h0;
                    end
                end
                RX_START:
                begin
                    // glitch rejection: start must still be low at mid-bit
                    if (r.os == abir_pkg::OS_MID)
                    begin
                        n.st    = s ? RX_IDLE : RX_DATA;
                        n.os    = 4'h0;
                        n.nbits = 4'h0;
                    end
                end
                RX_DATA:
                begin
                    if (r.os == abir_pkg::OS_LAST)
                    begin
                        n.sh    = {s, r.sh[8:1]};
                        n.nbits = r.nbits + 4'h1;
                        if (r.nbits == (lnk.nine_bit ? 4'h8 : 4'h7))
                        begin
                            n.st = RX_STOP;
                        end
                    end
                end
                RX_STOP:
                begin
                    if (r.os == abir_pkg::OS_LAST)
                    begin
                        n.st    = RX_IDLE;
                        n.valid = 1'b1;
                        n.data  = lnk.nine_bit ? r.sh : {1'b0, r.sh[8:1]};
                        n.ferr  = !s;
                    end
                end
                default:
                begin
                    n.st = RX_IDLE;
                end
            endcase
        end
        if (!lnk.rx_on)
        begin
            n.st    = RX_IDLE;
            n.valid = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign lnk.char_valid = r.valid;
    assign lnk.char_data  = r.data;
    assign lnk.char_ferr  = r.ferr;

endmodule // abir_rx

// ==== hw/abir_rx_if.sv ====
/*
 * abir_rx_if: link between the port core and its receiver.
 * assumes: all signals are synchronous to the bus clock.
 */
`timescale 1ns/1ns
interface abir_rx_if;
    logic       os_tick;
    logic       rx_on;
    logic       rx_inv;
    logic       nine_bit;
    logic       rxd;
    logic       char_valid;
    logic [8:0] char_data;
    logic       char_ferr;

    modport core (output os_tick, rx_on, rx_inv, nine_bit, rxd,
                  input  char_valid, char_data, char_ferr);
    modport rx   (input  os_tick, rx_on, rx_inv, nine_bit, rxd,
                  output char_valid, char_data, char_ferr);
endinterface

// ==== hw/abir_top.sv ====
/*
 * abir_top: asynchronous serial port core: APB registers, transmitter with
 * break and queued idle, receive data register, interrupt.
 * assumes: APB3 master on pclk; rxd synchronous to pclk; the shared pin mux
 * gives the transmitter the pin while tx_drive_n is low.
 */
`timescale 1ns/1ns

// Behaviour
// - keep pin until queued activity finishes
// - break is whole character of zeros
// - break length from long and nine select
// - request one then zero queues break
// - request still one requeues a break
// - received break reads zero, framing error
// - tx_on off then on queues idle
// - pin kept while shifter still busy
// - receive input inverted when selected
// - receiver works only while rx_on
// - start, eight/nine lsb-first bits, stop
// - stop bit moves character if register empty
module abir_top (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // serial line
    input  wire logic        rxd,
    output logic             txd,
    output logic             tx_drive_n,
    // interrupt
    output logic             irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                        pready;
        logic [31:0]                 prdata;
        logic                        pslverr;
        logic                        tx_on;
        logic                        rx_on;
        logic                        brk_req;
        logic                        long_brk;
        logic                        nine_bit;
        logic                        rx_inv;
        logic [15:0]                 baud;
        logic [15:0]                 div_cnt;
        logic                        os_tick;
        logic [3:0]                  sub;
        abir_pkg::abir_kind_t [2:0]  q;
        logic [1:0]                  q_cnt;
        logic [8:0]                  tx_buf;
        logic                        tx_buf_full;
        abir_pkg::abir_kind_t        sh_kind;
        logic [13:0]                 sh;
        logic [3:0]                  bits_left;
        logic                        txd;
        logic                        tx_drive_n;
        logic [abir_pkg::ST_W-1:0]   status;
        logic [abir_pkg::ST_W-1:0]   irq_en;
        logic                        irq;
        logic [8:0]                  rx_data;
        logic                        rx_full;
    } abir_core_t;

    abir_core_t r;
    abir_core_t n;

    abir_rx_if  rxl ();

    abir_rx u_rx (
        .pclk    (pclk),
        .presetn (presetn),
        .lnk     (rxl.rx)
    );

    assign rxl.os_tick  = r.os_tick;
    assign rxl.rx_on    = r.rx_on;
    assign rxl.rx_inv   = r.rx_inv;
    assign rxl.nine_bit = r.nine_bit;
    assign rxl.rxd      = rxd;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic q_has(input abir_pkg::abir_kind_t [2:0] q,
                                   input logic [1:0] cnt,
                                   input abir_pkg::abir_kind_t k);
        logic found;
        found = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            if ((2'(i) < cnt) && (q[i] == k))
            begin
                found = 1'b1;
            end
        end
        return found;
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic                      setup;
    logic                      acc_wr;
    logic                      acc_rd;
    logic                      push_data;
    logic                      push_brk;
    logic                      push_idle;
    logic [abir_pkg::ST_W-1:0] st_set;
    logic [abir_pkg::ST_W-1:0] st_clr;
    logic [13:0]               frame;
    logic [3:0]                len;

    always_comb
    begin
        n         = r;
        push_data = 1'b0;
        push_brk  = 1'b0;
        push_idle = 1'b0;
        st_set    = '0;
        st_clr    = '0;
        frame     = '1;
        len       = abir_pkg::LEN_CHAR8;
        setup     = psel && !penable;
        acc_wr    = psel && penable && r.pready && pwrite;
        acc_rd    = psel && penable && r.pready && !pwrite;

        // oversample divider: one enable pulse per sixteenth of a bit
        n.os_tick = 1'b0;
        if (r.div_cnt >= r.baud)
        begin
            n.div_cnt = '0;
            n.os_tick = 1'b1;
        end
        else
        begin
            n.div_cnt = r.div_cnt + 16'h0001;
        end

        // apb: read data captured in setup, zero wait states
        n.pready  = setup;
        // the error flag stands only beside ready
        n.pslverr = 1'b0;
        if (setup)
        begin
            n.prdata  = '0;
            case (paddr)
                abir_pkg::OFF_CTRL:
                    n.prdata = {26'h0, r.rx_inv, r.nine_bit, r.long_brk,
                                r.brk_req, r.rx_on, r.tx_on};
                abir_pkg::OFF_BAUD:    n.prdata = {16'h0, r.baud};
                abir_pkg::OFF_TXDATA:  n.prdata = '0;
                abir_pkg::OFF_RXDATA:  n.prdata = {23'h0, r.rx_data};
                abir_pkg::OFF_STATUS:  n.prdata = {27'h0, r.status};
                abir_pkg::OFF_IRQ_CLR: n.prdata = '0;
                abir_pkg::OFF_IRQ_EN:  n.prdata = {27'h0, r.irq_en};
                abir_pkg::OFF_STATE:
                    n.prdata = {28'h0, r.sh_kind != abir_pkg::KIND_NONE,
                                !r.tx_drive_n, r.rx_full, !r.tx_buf_full};
                default:               n.pslverr = 1'b1;
            endcase
        end

        if (acc_wr)
        begin
            case (paddr)
                abir_pkg::OFF_CTRL:
                begin
                    n.tx_on    = pwdata[abir_pkg::CTRL_TX_ON];
                    n.rx_on    = pwdata[abir_pkg::CTRL_RX_ON];
                    n.brk_req  = pwdata[abir_pkg::CTRL_BRK_REQ];
                    n.long_brk = pwdata[abir_pkg::CTRL_LONG_BRK];
                    n.nine_bit = pwdata[abir_pkg::CTRL_NINE_BIT];
                    n.rx_inv   = pwdata[abir_pkg::CTRL_RX_INV];
                    push_brk   = r.brk_req && !n.brk_req;
                    push_idle  = !r.tx_on && n.tx_on;
                end
                abir_pkg::OFF_BAUD:
                    n.baud = pwdata[15:0];
                abir_pkg::OFF_TXDATA:
                begin
                    // a write into a full buffer is dropped
                    if (!r.tx_buf_full)
                    begin
                        n.tx_buf      = pwdata[8:0];
                        n.tx_buf_full = 1'b1;
                        push_data     = 1'b1;
                    end
                end
                abir_pkg::OFF_IRQ_CLR:
                    st_clr = pwdata[abir_pkg::ST_W-1:0];
                abir_pkg::OFF_IRQ_EN:
                    n.irq_en = pwdata[abir_pkg::ST_W-1:0];
                default:
                    n.irq_en = r.irq_en;
            endcase
        end

        // ------------------------------------------------------------------
        // transmitter, stepped on bit boundaries of the baud clock
        // ------------------------------------------------------------------
        if (r.os_tick)
        begin
            n.sub = r.sub + 4'h1;
            if (r.sub == abir_pkg::OS_LAST)
            begin
                // no new character until current one ends
                if (r.bits_left != 4'h0)
                begin
                    n.txd       = r.sh[0];
                    n.sh        = {1'b1, r.sh[13:1]};
                    n.bits_left = r.bits_left - 4'h1;
                end
                else
                begin
                    if (r.sh_kind != abir_pkg::KIND_NONE)
                    begin
                        st_set[abir_pkg::ST_TX_DONE] = 1'b1;
                    end
                    n.sh_kind = abir_pkg::KIND_NONE;
                    n.txd     = 1'b1;
                    if (r.q_cnt != 2'h0)
                    begin
                        n.sh_kind = r.q[0];
                        n.q[0]    = r.q[1];
                        n.q[1]    = r.q[2];
                        n.q[2]    = abir_pkg::KIND_NONE;
                        n.q_cnt   = r.q_cnt - 2'h1;
                        len       = r.nine_bit ? abir_pkg::LEN_CHAR9
                                               : abir_pkg::LEN_CHAR8;
                        case (r.q[0])
                            abir_pkg::KIND_DATA:
                            begin
                                frame = r.nine_bit ? {4'hf, r.tx_buf, 1'b0}
                                                   : {5'h1f, r.tx_buf[7:0], 1'b0};
                                n.tx_buf_full = 1'b0;
                                st_set[abir_pkg::ST_TX_EMPTY] = 1'b1;
                            end
                            abir_pkg::KIND_BREAK:
                            begin
                                frame = '0;
                                // length from long and nine select
                                case ({r.long_brk, r.nine_bit})
                                    2'b00:   len = abir_pkg::LEN_CHAR8;
                                    2'b01:   len = abir_pkg::LEN_CHAR9;
                                    2'b10:   len = abir_pkg::LEN_LONG_BREAK_SELECT;
                                    default: len = abir_pkg::LEN_BRK14;
                                endcase
                                if (n.brk_req)
                                begin
                                    push_brk = 1'b1;
                                end
                            end
                            default:
                                frame = '1;
                        endcase
                        n.txd       = frame[0];
                        n.sh        = {1'b1, frame[13:1]};
                        n.bits_left = len - 4'h1;
                    end
                end
            end
        end

        // queue pushes after the pop; one entry per kind at most
        if (push_data && !q_has(n.q, n.q_cnt, abir_pkg::KIND_DATA))
        begin
            n.q[n.q_cnt] = abir_pkg::KIND_DATA;
            n.q_cnt      = n.q_cnt + 2'h1;
        end
        if (push_brk && !q_has(n.q, n.q_cnt, abir_pkg::KIND_BREAK))
        begin
            n.q[n.q_cnt] = abir_pkg::KIND_BREAK;
            n.q_cnt      = n.q_cnt + 2'h1;
        end
        if (push_idle && !q_has(n.q, n.q_cnt, abir_pkg::KIND_IDLE))
        begin
            n.q[n.q_cnt] = abir_pkg::KIND_IDLE;
            n.q_cnt      = n.q_cnt + 2'h1;
        end

        // pin held while anything is in flight or queued
        // so a quick off-on never lets the pin go while a character is in flight or queued
        n.tx_drive_n = !(n.tx_on || (n.sh_kind != abir_pkg::KIND_NONE)
                         || (n.q_cnt != 2'h0));
        if (n.tx_drive_n)
        begin
            n.txd = 1'b1;
        end

        // ------------------------------------------------------------------
        // receive data register
        // ------------------------------------------------------------------
        if (acc_rd && (paddr == abir_pkg::OFF_RXDATA))
        begin
            n.rx_full = 1'b0;
        end
        if (rxl.char_valid)
        begin
            if (!r.rx_full)
            begin
                n.rx_data = rxl.char_data;
                n.rx_full = 1'b1;
                st_set[abir_pkg::ST_RX_FULL]   = 1'b1;
                st_set[abir_pkg::ST_FRAME_ERR] = rxl.char_ferr;
            end
            else
            begin
                st_set[abir_pkg::ST_OVERRUN] = 1'b1;
            end
        end

        // sticky status: a new event beats a clear in the same cycle
        n.status = (r.status & ~st_clr) | st_set;
        n.irq    = |(n.status & n.irq_en);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r            <= '0;
            r.baud       <= abir_pkg::BAUD_RST;
            r.txd        <= 1'b1;
            r.tx_drive_n <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    assign prdata     = r.prdata;
    assign pready     = r.pready;
    assign pslverr    = r.pslverr;
    assign txd        = r.txd;
    assign tx_drive_n = r.tx_drive_n;
    assign irq        = r.irq;

endmodule // abir_top

// ==== verif/abir_peer.sv ====
/*
 * abir_peer: remote transceiver that drives the receive line.
 * assumes: one bit lasts BIT pclk cycles, matching the port's baud setting.
 */
`timescale 1ns/1ns
module abir_peer #(parameter int BIT = 16) (
    // clock and line
    input  wire logic pclk,
    output logic      line
);
    logic inv = 1'b0;
    initial line = 1'b1;
    task automatic put(input logic b);
        line <= b ^ inv;
        repeat (BIT) @(posedge pclk);
    endtask
    task automatic send(input logic [7:0] d, input logic stop);
        @(posedge pclk);
        put(1'b0);
        for (int i = 0; i < 8; i++) put(d[i]);
        put(stop);
        repeat (10) put(1'b1);
    endtask
endmodule // abir_peer

// ==== verif/abir_props.sv ====
/*
 * abir_props: port-level checks of bus handshake, line ownership and interrupt masking.
 * assumes: bound onto every abir_top; one clock domain.
 */
`timescale 1ns/1ns
module abir_props (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // line and interrupt
    input wire logic        txd,
    input wire logic        tx_drive_n,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_unmapped: assert property (pready && paddr > 8'h1c |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_released_high: assert property (tx_drive_n |-> txd)
        else $error("released line not high");
    a_rdata_held: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
    // masking every source must drop the request within two edges
    a_irq_masked: assert property (psel && penable && pwrite && paddr == 8'h18
        && pwdata == 32'h0 |-> ##2 !irq)
        else $error("interrupt stays after mask");
    c_break: cover property (!txd [*8] ##1 txd);
    c_irq: cover property ($rose(irq));
    c_refused: cover property (pslverr);
endmodule // abir_props

bind abir_top abir_props i_props (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txd(txd), .tx_drive_n(tx_drive_n), .irq(irq));

// ==== verif/tb_top.sv ====
/*
 * tb_top: directed bench for abir_top with a remote peer on the receive line.
 * assumes: baud register written to zero, so one bit lasts 16 pclk cycles.
 */
`timescale 1ns/1ns
module tb_top;
    localparam logic [7:0] A_CT = abir_pkg::OFF_CTRL;
    localparam logic [7:0] A_TX = abir_pkg::OFF_TXDATA;
    localparam logic [7:0] A_RX = abir_pkg::OFF_RXDATA;
    localparam logic [7:0] A_ST = abir_pkg::OFF_STATUS;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxd;
    logic        txd;
    logic        tx_drive_n;
    logic        irq;
    // gpio holds the shared pin high once released
    wire         line_out = tx_drive_n ? 1'b1 : txd;
    logic [31:0] rd;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          run = 0;
    int          last = 0;
    int          last_at = 0;
    int          t;
    always #5 pclk = ~pclk;
    abir_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
        .tx_drive_n(tx_drive_n), .irq(irq));
    abir_peer i_peer (.pclk(pclk), .line(rxd));
    // ------------------------------------------------------------------
    // low-run monitor and hang guard
    // ------------------------------------------------------------------
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (line_out === 1'b0)
            run <= run + 1;
        else if (run != 0)
        begin
            last <= run;
            last_at <= cycles;
            run <= 0;
        end
        if (cycles == 20000)
        begin
            bad_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (bad_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // waits for one whole low run on the transmit line
    task automatic await_run();
        for (int i = 0; i < 600 && txd !== 1'b0; i++) @(posedge pclk);
        for (int i = 0; i < 600 && txd !== 1'b1; i++) @(posedge pclk);
        @(posedge pclk);
    endtask
    task automatic s_regs();
        apb(1'b0, A_CT, 32'h0);
        chk("ctrl", rd, 32'h0);
        apb(1'b0, abir_pkg::OFF_BAUD, 32'h0);
        chk("baud", rd, 32'h35);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", rd, 32'h0);
        chk("refused", pslverr, 32'h1);
        apb(1'b1, abir_pkg::OFF_BAUD, 32'h0);
    endtask
    task automatic s_break();
        int len [4] = '{10, 11, 13, 14};
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, A_CT, {27'h0, i[0], i[1], 3'h5});
            apb(1'b1, A_CT, {27'h0, i[0], i[1], 3'h1});
            await_run();
            chk("break bits", last, len[i] * 16);
        end
    endtask
    task automatic s_rebreak();
        // ninth bit high: one low start bit in either width
        apb(1'b1, A_TX, 32'h1ff);
        apb(1'b1, A_CT, 32'h5);
        apb(1'b1, A_CT, 32'h1);
        apb(1'b1, A_CT, 32'h5);
        await_run();
        chk("start bit", last, 16);
        repeat (200) @(posedge pclk);
        apb(1'b1, A_CT, 32'h1);
        await_run();
        chk("rebreak bits", last, 320);
    endtask
    task automatic s_idle();
        apb(1'b1, A_TX, 32'hff);
        await_run();
        t = last_at;
        // idle requested only once data is in shifter
        apb(1'b1, A_CT, 32'h0);
        apb(1'b1, A_CT, 32'h1);
        apb(1'b1, A_TX, 32'h0);
        chk("pin kept", tx_drive_n, 1'b0);
        await_run();
        chk("idle gap", last_at - t, 448);
    endtask
    task automatic s_release();
        apb(1'b1, A_TX, 32'h55);
        apb(1'b1, A_CT, 32'h0);
        repeat (80) @(posedge pclk);
        chk("drain held", tx_drive_n, 1'b0);
        repeat (150) @(posedge pclk);
        chk("released", {txd, tx_drive_n}, 2'h3);
    endtask
    task automatic s_rx();
        apb(1'b1, abir_pkg::OFF_IRQ_EN, 32'h2);
        apb(1'b1, A_CT, 32'h2);
        i_peer.send(8'ha5, 1'b1);
        chk("irq raised", irq, 1'b1);
        apb(1'b0, A_RX, 32'h0);
        chk("rx data", rd, 32'ha5);
        i_peer.send(8'h3c, 1'b1);
        i_peer.send(8'hc3, 1'b1);
        apb(1'b0, A_RX, 32'h0);
        chk("kept data", rd, 32'h3c);
        apb(1'b0, A_ST, 32'h0);
        chk("overrun", rd[3], 1'b1);
        apb(1'b1, abir_pkg::OFF_IRQ_EN, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq masked", irq, 1'b0);
        apb(1'b1, abir_pkg::OFF_IRQ_CLR, 32'h1f);
        apb(1'b0, A_ST, 32'h0);
        chk("cleared", rd, 32'h0);
        i_peer.send(8'h00, 1'b0);
        apb(1'b0, A_RX, 32'h0);
        chk("break data", rd, 32'h0);
        apb(1'b0, A_ST, 32'h0);
        chk("frame err", rd[2], 1'b1);
        apb(1'b1, A_CT, 32'h0);
        i_peer.send(8'h11, 1'b1);
        apb(1'b0, abir_pkg::OFF_STATE, 32'h0);
        chk("rx off", rd[1], 1'b0);
        i_peer.inv = 1'b1;
        i_peer.put(1'b1);
        apb(1'b1, A_CT, 32'h22);
        i_peer.send(8'h5a, 1'b1);
        apb(1'b0, A_RX, 32'h0);
        chk("inverted", rd, 32'h5a);
    endtask
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        s_break();
        s_rebreak();
        s_idle();
        s_release();
        s_rx();
        complete_run();
    end
endmodule // tb_top
